// ---- logic/buck_regs_pkg.sv ----
package buck_regs_pkg;

  // ==========================================================================
  // Clock and step timing
  localparam int unsigned CLK_PERIOD_NS    = 100;
  localparam int unsigned STEP_FAST_NS     = 2000;
  localparam int unsigned STEP_SLOW_NS     = 4000;
  localparam int unsigned STEP_FAST_CYCLES = (STEP_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STEP_SLOW_CYCLES = (STEP_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STEP_CNT_W       = 6;

  // ==========================================================================
  // Bus layout
  localparam int unsigned ADDR_W      = 10;
  localparam int unsigned INDEX_W     = 8;
  localparam int unsigned INDEX_LO    = 2;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned REG_W       = 8;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_BUCK_A_CONFIG   = 8'h32;
  localparam logic [7:0] IDX_BUCK_B_NORMAL   = 8'h35;
  localparam logic [7:0] IDX_BUCK_B_STANDBY  = 8'h36;
  localparam logic [7:0] IDX_BUCK_B_SLEEP    = 8'h37;
  localparam logic [7:0] IDX_BUCK_B_MODE     = 8'h38;
  localparam logic [7:0] IDX_BUCK_STATUS     = 8'h3f;

  // ==========================================================================
  // Field positions and fixed reset values
  localparam int unsigned A_STEP_BIT   = 6;
  localparam int unsigned A_PHASE_LO   = 4;
  localparam int unsigned A_FREQ_LO    = 2;
  localparam int unsigned A_ILIM_BIT   = 0;
  localparam int unsigned B_CODE_LO    = 0;
  localparam int unsigned B_CODE_W     = 5;
  localparam int unsigned B_RANGE_BIT  = 5;
  localparam int unsigned B_OFFSEL_BIT = 5;
  localparam int unsigned B_MODE_LO    = 0;
  localparam int unsigned B_MODE_W     = 4;
  localparam int unsigned ST_STATE_LO  = 0;
  localparam int unsigned ST_STBY_BIT  = 2;
  localparam logic [1:0]  A_PHASE_RESET  = 2'h0;
  localparam logic        B_OFFSEL_RESET = 1'h0;

  typedef enum logic [2:0]
  {
    SEL_NONE      = 3'h0,
    SEL_A_CONFIG  = 3'h1,
    SEL_B_NORMAL  = 3'h2,
    SEL_B_STANDBY = 3'h3,
    SEL_B_SLEEP   = 3'h4,
    SEL_B_MODE    = 3'h5,
    SEL_STATUS    = 3'h6
  } reg_sel_t;

  typedef enum logic [1:0]
  {
    B_ON    = 2'h0,
    B_OFF   = 2'h1,
    B_SLEEP = 2'h2
  } buck_b_state_t;

endpackage

// ---- logic/reg_access_if.sv ----
`timescale 1ns/1ps

interface reg_access_if;
  logic       wr_en;
  logic [7:0] wr_index;
  logic [7:0] wr_data;
  logic       wr_lane;
  logic       wr_hit;
  logic [7:0] rd_index;
  logic [7:0] rd_data;
  logic       rd_hit;

  modport port
  (
    output wr_en, wr_index, wr_data, wr_lane, rd_index,
    input  wr_hit, rd_data, rd_hit
  );

  modport bank
  (
    input  wr_en, wr_index, wr_data, wr_lane, rd_index,
    output wr_hit, rd_data, rd_hit
  );
endinterface

// ---- logic/dvs_step_timer.sv ----
`timescale 1ns/1ps

module dvs_step_timer
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic slow,
  output logic      tick
);
  localparam logic [buck_regs_pkg::STEP_CNT_W-1:0] FAST_LAST =
    buck_regs_pkg::STEP_CNT_W'(buck_regs_pkg::STEP_FAST_CYCLES - 1);
  localparam logic [buck_regs_pkg::STEP_CNT_W-1:0] SLOW_LAST =
    buck_regs_pkg::STEP_CNT_W'(buck_regs_pkg::STEP_SLOW_CYCLES - 1);

  logic [buck_regs_pkg::STEP_CNT_W-1:0] count;
  logic                                 at_end;

  assign at_end = (count >= (slow ? SLOW_LAST : FAST_LAST));

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      count <= at_end ? '0 : count + 1'b1;
      tick  <= at_end;
    end
  end
endmodule

// ---- logic/axil_reg_port.sv ----
`timescale 1ns/1ps

module axil_reg_port
(
  input  wire logic                             clk,
  input  wire logic                             rst,
  input  wire logic [buck_regs_pkg::ADDR_W-1:0] s_axil_awaddr,
  input  wire logic                             s_axil_awvalid,
  output logic                                  s_axil_awready,
  input  wire logic [buck_regs_pkg::DATA_W-1:0] s_axil_wdata,
  input  wire logic [3:0]                       s_axil_wstrb,
  input  wire logic                             s_axil_wvalid,
  output logic                                  s_axil_wready,
  output logic [1:0]                            s_axil_bresp,
  output logic                                  s_axil_bvalid,
  input  wire logic                             s_axil_bready,
  input  wire logic [buck_regs_pkg::ADDR_W-1:0] s_axil_araddr,
  input  wire logic                             s_axil_arvalid,
  output logic                                  s_axil_arready,
  output logic [buck_regs_pkg::DATA_W-1:0]      s_axil_rdata,
  output logic [1:0]                            s_axil_rresp,
  output logic                                  s_axil_rvalid,
  input  wire logic                             s_axil_rready,
  reg_access_if.port                            regs
);
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_index;
  logic [7:0] w_byte;
  logic       w_lane;

  // ==========================================================================
  // Write channel
  assign s_axil_awready = !aw_held && !s_axil_bvalid;
  assign s_axil_wready  = !w_held && !s_axil_bvalid;
  assign regs.wr_en     = aw_held && w_held && !s_axil_bvalid;
  assign regs.wr_index  = aw_index;
  assign regs.wr_data   = w_byte;
  assign regs.wr_lane   = w_lane;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_index      <= '0;
      w_byte        <= '0;
      w_lane        <= 1'b0;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp  <= buck_regs_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axil_awvalid && s_axil_awready)
      begin
        aw_held  <= 1'b1;
        aw_index <= s_axil_awaddr[buck_regs_pkg::INDEX_LO +: buck_regs_pkg::INDEX_W];
      end
      if (s_axil_wvalid && s_axil_wready)
      begin
        w_held <= 1'b1;
        w_byte <= s_axil_wdata[buck_regs_pkg::REG_W-1:0];
        w_lane <= s_axil_wstrb[0];
      end
      if (regs.wr_en)
      begin
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axil_bvalid <= 1'b1;
        s_axil_bresp  <= regs.wr_hit ? buck_regs_pkg::RESP_OKAY : buck_regs_pkg::RESP_SLVERR;
      end
      else if (s_axil_bready)
      begin
        s_axil_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Read channel
  assign s_axil_arready = !s_axil_rvalid;
  assign regs.rd_index  = s_axil_araddr[buck_regs_pkg::INDEX_LO +: buck_regs_pkg::INDEX_W];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_axil_rvalid <= 1'b0;
      s_axil_rdata  <= '0;
      s_axil_rresp  <= buck_regs_pkg::RESP_OKAY;
    end
    else if (s_axil_arvalid && s_axil_arready)
    begin
      s_axil_rvalid <= 1'b1;
      s_axil_rdata  <= {{(buck_regs_pkg::DATA_W-buck_regs_pkg::REG_W){1'b0}}, regs.rd_data};
      s_axil_rresp  <= regs.rd_hit ? buck_regs_pkg::RESP_OKAY : buck_regs_pkg::RESP_SLVERR;
    end
    else if (s_axil_rready)
    begin
      s_axil_rvalid <= 1'b0;
    end
  end
endmodule

// ---- logic/buck_regulator_config_regs.sv ----
`timescale 1ns/1ps

module buck_regulator_config_regs
(
  input  wire logic                             clk,
  input  wire logic                             rst,
  input  wire logic [buck_regs_pkg::ADDR_W-1:0] s_axil_awaddr,
  input  wire logic                             s_axil_awvalid,
  output logic                                  s_axil_awready,
  input  wire logic [buck_regs_pkg::DATA_W-1:0] s_axil_wdata,
  input  wire logic [3:0]                       s_axil_wstrb,
  input  wire logic                             s_axil_wvalid,
  output logic                                  s_axil_wready,
  output logic [1:0]                            s_axil_bresp,
  output logic                                  s_axil_bvalid,
  input  wire logic                             s_axil_bready,
  input  wire logic [buck_regs_pkg::ADDR_W-1:0] s_axil_araddr,
  input  wire logic                             s_axil_arvalid,
  output logic                                  s_axil_arready,
  output logic [buck_regs_pkg::DATA_W-1:0]      s_axil_rdata,
  output logic [1:0]                            s_axil_rresp,
  output logic                                  s_axil_rvalid,
  input  wire logic                             s_axil_rready,
  input  wire logic                             otp_buck_a_step_rate,
  input  wire logic [1:0]                       otp_buck_a_frequency_select,
  input  wire logic                             otp_buck_a_current_limit,
  input  wire logic [5:0]                       otp_buck_b_normal_voltage,
  input  wire logic [5:0]                       otp_buck_b_standby_voltage,
  input  wire logic [5:0]                       otp_buck_b_sleep_voltage,
  input  wire logic [3:0]                       otp_buck_b_mode_select,
  input  wire logic                             standby_request,
  input  wire logic                             turn_off_event,
  input  wire logic                             turn_on_event,
  output logic                                  buck_a_step_rate,
  output logic                                  buck_a_step_tick,
  output logic [1:0]                            buck_a_phase_select,
  output logic [1:0]                            buck_a_frequency_select,
  output logic                                  buck_a_current_limit,
  output logic [4:0]                            buck_b_code,
  output logic                                  buck_b_high_range,
  output logic [3:0]                            buck_b_mode_select,
  output logic                                  buck_b_enable,
  output logic [1:0]                            buck_b_state
);
  reg_access_if regs ();

  logic [5:0]                   buck_b_normal_voltage;
  logic [5:0]                   buck_b_standby_voltage;
  logic [5:0]                   buck_b_sleep_voltage;
  logic                         buck_b_off_state_select;
  buck_regs_pkg::buck_b_state_t state;
  buck_regs_pkg::buck_b_state_t next_state;
  logic [5:0]                   next_voltage;
  buck_regs_pkg::reg_sel_t      wr_sel;
  buck_regs_pkg::reg_sel_t      rd_sel;
  logic                         wr_go;

  // ==========================================================================
  // Address decode
  function automatic buck_regs_pkg::reg_sel_t decode(input logic [7:0] index);
    unique case (index)
      buck_regs_pkg::IDX_BUCK_A_CONFIG:  decode = buck_regs_pkg::SEL_A_CONFIG;
      buck_regs_pkg::IDX_BUCK_B_NORMAL:  decode = buck_regs_pkg::SEL_B_NORMAL;
      buck_regs_pkg::IDX_BUCK_B_STANDBY: decode = buck_regs_pkg::SEL_B_STANDBY;
      buck_regs_pkg::IDX_BUCK_B_SLEEP:   decode = buck_regs_pkg::SEL_B_SLEEP;
      buck_regs_pkg::IDX_BUCK_B_MODE:    decode = buck_regs_pkg::SEL_B_MODE;
      buck_regs_pkg::IDX_BUCK_STATUS:    decode = buck_regs_pkg::SEL_STATUS;
      default:                           decode = buck_regs_pkg::SEL_NONE;
    endcase
  endfunction

  assign wr_sel      = decode(regs.wr_index);
  assign rd_sel      = decode(regs.rd_index);
  assign regs.wr_hit = (wr_sel != buck_regs_pkg::SEL_NONE);
  assign regs.rd_hit = (rd_sel != buck_regs_pkg::SEL_NONE);
  assign wr_go       = regs.wr_en && regs.wr_lane;

  // ==========================================================================
  // Bus port
  axil_reg_port port_i
  (
    .clk            (clk),
    .rst            (rst),
    .s_axil_awaddr  (s_axil_awaddr),
    .s_axil_awvalid (s_axil_awvalid),
    .s_axil_awready (s_axil_awready),
    .s_axil_wdata   (s_axil_wdata),
    .s_axil_wstrb   (s_axil_wstrb),
    .s_axil_wvalid  (s_axil_wvalid),
    .s_axil_wready  (s_axil_wready),
    .s_axil_bresp   (s_axil_bresp),
    .s_axil_bvalid  (s_axil_bvalid),
    .s_axil_bready  (s_axil_bready),
    .s_axil_araddr  (s_axil_araddr),
    .s_axil_arvalid (s_axil_arvalid),
    .s_axil_arready (s_axil_arready),
    .s_axil_rdata   (s_axil_rdata),
    .s_axil_rresp   (s_axil_rresp),
    .s_axil_rvalid  (s_axil_rvalid),
    .s_axil_rready  (s_axil_rready),
    .regs           (regs.port)
  );

  // ==========================================================================
  // First buck configuration
  // OTP and zero resets
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      buck_a_step_rate        <= otp_buck_a_step_rate;
      buck_a_phase_select     <= buck_regs_pkg::A_PHASE_RESET;
      buck_a_frequency_select <= otp_buck_a_frequency_select;
      buck_a_current_limit    <= otp_buck_a_current_limit;
    end
    else if (wr_go && wr_sel == buck_regs_pkg::SEL_A_CONFIG)
    begin
      buck_a_step_rate        <= regs.wr_data[buck_regs_pkg::A_STEP_BIT];
      buck_a_phase_select     <= regs.wr_data[buck_regs_pkg::A_PHASE_LO +: 2];
      buck_a_frequency_select <= regs.wr_data[buck_regs_pkg::A_FREQ_LO +: 2];
      buck_a_current_limit    <= regs.wr_data[buck_regs_pkg::A_ILIM_BIT];
    end
  end

  // step period 20 or 40 cycles
  dvs_step_timer step_i
  (
    .clk  (clk),
    .rst  (rst),
    .slow (buck_a_step_rate),
    .tick (buck_a_step_tick)
  );

  // ==========================================================================
  // Second buck voltage registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      buck_b_normal_voltage  <= otp_buck_b_normal_voltage;
      buck_b_standby_voltage <= otp_buck_b_standby_voltage;
      buck_b_sleep_voltage   <= otp_buck_b_sleep_voltage;
    end
    else if (wr_go)
    begin
      if (wr_sel == buck_regs_pkg::SEL_B_NORMAL)
      begin
        buck_b_normal_voltage <= regs.wr_data[5:0];
      end
      if (wr_sel == buck_regs_pkg::SEL_B_STANDBY)
      begin
        buck_b_standby_voltage <= regs.wr_data[5:0];
      end
      if (wr_sel == buck_regs_pkg::SEL_B_SLEEP)
      begin
        buck_b_sleep_voltage <= regs.wr_data[5:0];
      end
    end
  end

  // ==========================================================================
  // Second buck mode register
  // off bit and selector
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      buck_b_off_state_select <= buck_regs_pkg::B_OFFSEL_RESET;
      buck_b_mode_select      <= otp_buck_b_mode_select;
    end
    else if (wr_go && wr_sel == buck_regs_pkg::SEL_B_MODE)
    begin
      buck_b_off_state_select <= regs.wr_data[buck_regs_pkg::B_OFFSEL_BIT];
      buck_b_mode_select      <= regs.wr_data[buck_regs_pkg::B_MODE_LO +: buck_regs_pkg::B_MODE_W];
    end
  end

  // ==========================================================================
  // Second buck operating state
  always_comb
  begin
    next_state = state;
    if (turn_off_event)
    begin
      next_state = buck_b_off_state_select ? buck_regs_pkg::B_SLEEP : buck_regs_pkg::B_OFF;
    end
    else if (turn_on_event)
    begin
      next_state = buck_regs_pkg::B_ON;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= buck_regs_pkg::B_ON;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_comb
  begin
    next_voltage = buck_b_normal_voltage;
    unique case (state)
      buck_regs_pkg::B_ON:    next_voltage = standby_request ? buck_b_standby_voltage : buck_b_normal_voltage;
      buck_regs_pkg::B_SLEEP:
      begin
        next_voltage = buck_b_sleep_voltage;
      end
      buck_regs_pkg::B_OFF:
      begin
        next_voltage = buck_b_normal_voltage;
      end
      default:                next_voltage = buck_b_normal_voltage;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      buck_b_code       <= '0;
      buck_b_high_range <= 1'b0;
      buck_b_enable     <= 1'b0;
      buck_b_state      <= buck_regs_pkg::B_ON;
    end
    else
    begin
      buck_b_code       <= next_voltage[buck_regs_pkg::B_CODE_LO +: buck_regs_pkg::B_CODE_W];
      buck_b_high_range <= next_voltage[buck_regs_pkg::B_RANGE_BIT];
      buck_b_enable     <= (state != buck_regs_pkg::B_OFF);
      buck_b_state      <= state;
    end
  end

  // ==========================================================================
  // Read data
  // every register readable
  always_comb
  begin
    regs.rd_data = '0;
    unique case (rd_sel)
      buck_regs_pkg::SEL_A_CONFIG:
      begin
        regs.rd_data[buck_regs_pkg::A_STEP_BIT]      = buck_a_step_rate;
        regs.rd_data[buck_regs_pkg::A_PHASE_LO +: 2] = buck_a_phase_select;
        regs.rd_data[buck_regs_pkg::A_FREQ_LO +: 2]  = buck_a_frequency_select;
        regs.rd_data[buck_regs_pkg::A_ILIM_BIT]      = buck_a_current_limit;
      end
      buck_regs_pkg::SEL_B_NORMAL:
      begin
        regs.rd_data[5:0] = buck_b_normal_voltage;
      end
      buck_regs_pkg::SEL_B_STANDBY:
      begin
        regs.rd_data[5:0] = buck_b_standby_voltage;
      end
      buck_regs_pkg::SEL_B_SLEEP:
      begin
        regs.rd_data[5:0] = buck_b_sleep_voltage;
      end
      buck_regs_pkg::SEL_B_MODE:
      begin
        regs.rd_data[buck_regs_pkg::B_OFFSEL_BIT]                         = buck_b_off_state_select;
        regs.rd_data[buck_regs_pkg::B_MODE_LO +: buck_regs_pkg::B_MODE_W] = buck_b_mode_select;
      end
      buck_regs_pkg::SEL_STATUS:
      begin
        regs.rd_data[buck_regs_pkg::ST_STATE_LO +: 2] = state;
        regs.rd_data[buck_regs_pkg::ST_STBY_BIT]      = standby_request;
      end
      buck_regs_pkg::SEL_NONE:      regs.rd_data = '0;
      default:                      regs.rd_data = '0;
    endcase
  end
endmodule

// ---- sim/buck_regulator_config_regs_props.sv ----
`timescale 1ns/1ps

module buck_regulator_config_regs_props
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        s_axil_awready,
  input wire logic        s_axil_wready,
  input wire logic        s_axil_bvalid,
  input wire logic        s_axil_bready,
  input wire logic [1:0]  s_axil_bresp,
  input wire logic        s_axil_arvalid,
  input wire logic        s_axil_arready,
  input wire logic        s_axil_rvalid,
  input wire logic        s_axil_rready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic        turn_off_event,
  input wire logic        buck_a_step_rate,
  input wire logic        buck_a_step_tick,
  input wire logic [1:0]  buck_a_phase_select,
  input wire logic        buck_b_enable,
  input wire logic [1:0]  buck_b_state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Cycles since last tick, trusted only with a steady rate
  logic [6:0] gap;
  logic       gap_ok;

  always_ff @(posedge clk)
  begin
    if (rst || buck_a_step_tick)
      gap <= 7'h01;
    else
      gap <= gap + 7'h01;
  end

  always_ff @(posedge clk)
  begin
    if (rst || s_axil_bvalid || $changed(buck_a_step_rate))
      gap_ok <= 1'b0;
    else if (buck_a_step_tick)
      gap_ok <= 1'b1;
  end

  // ==========================================================================
  // Properties
  a_tick_period: assert property (gap_ok && !s_axil_bvalid && $stable(buck_a_step_rate) |->
    (buck_a_step_tick ? gap == (buck_a_step_rate ? 7'h28 : 7'h14) : gap < (buck_a_step_rate ? 7'h28 : 7'h14)))
    else $error("step tick spacing wrong");
  a_tick_single: assert property (buck_a_step_tick |=> !buck_a_step_tick)
    else $error("step tick longer than one cycle");
  a_write_hold: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp))
    else $error("write response dropped early");
  a_write_block: assert property (s_axil_bvalid |-> !s_axil_awready && !s_axil_wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
    else $error("read not answered next cycle");
  a_read_hold: assert property (s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata))
    else $error("read data dropped early");
  a_read_upper: assert property (s_axil_rvalid |-> s_axil_rdata[31:8] == 24'h000000)
    else $error("read data above byte not zero");
  a_off_leaves_on: assert property (turn_off_event |-> ##2 buck_b_state != buck_regs_pkg::B_ON)
    else $error("turn-off left regulator on");
  a_off_disables: assert property (buck_b_state == buck_regs_pkg::B_OFF |-> !buck_b_enable)
    else $error("enabled while off");
  a_phase_on_write: assert property ($changed(buck_a_phase_select) |-> s_axil_bvalid)
    else $error("phase changed without a write");
endmodule

bind buck_regulator_config_regs buck_regulator_config_regs_props i_props (.*);

// ---- sim/buck_regulator_config_regs_test.sv ----
`timescale 1ns/1ps

module buck_regulator_config_regs_test;
  logic        clk, rst, s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready, s_axil_bvalid;
  logic        s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid, s_axil_rready;
  logic        otp_buck_a_step_rate, otp_buck_a_current_limit, standby_request, turn_off_event, turn_on_event;
  logic        buck_a_step_rate, buck_a_step_tick, buck_a_current_limit, buck_b_high_range, buck_b_enable;
  logic [1:0]  s_axil_bresp, s_axil_rresp, otp_buck_a_frequency_select, buck_a_phase_select;
  logic [1:0]  buck_a_frequency_select, buck_b_state;
  logic [3:0]  s_axil_wstrb, otp_buck_b_mode_select, buck_b_mode_select;
  logic [4:0]  buck_b_code;
  logic [5:0]  otp_buck_b_normal_voltage, otp_buck_b_standby_voltage, otp_buck_b_sleep_voltage;
  logic [9:0]  s_axil_awaddr, s_axil_araddr;
  logic [31:0] s_axil_wdata, s_axil_rdata;
  int          miscompares, compares;

  localparam logic [9:0] A_CFG = {buck_regs_pkg::IDX_BUCK_A_CONFIG, 2'h0};
  localparam logic [9:0] B_NRM = {buck_regs_pkg::IDX_BUCK_B_NORMAL, 2'h0};
  localparam logic [9:0] B_STB = {buck_regs_pkg::IDX_BUCK_B_STANDBY, 2'h0};
  localparam logic [9:0] B_SLP = {buck_regs_pkg::IDX_BUCK_B_SLEEP, 2'h0};
  localparam logic [9:0] B_MOD = {buck_regs_pkg::IDX_BUCK_B_MODE, 2'h0};
  localparam logic [9:0] ST    = {buck_regs_pkg::IDX_BUCK_STATUS, 2'h0};
  localparam logic [1:0] OK    = buck_regs_pkg::RESP_OKAY;

  buck_regulator_config_regs i_dut (.*);

  always #50 clk = ~clk;

  // ==========================================================================
  // Bus cycles and comparison
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk);
    s_axil_awaddr  <= a;
    s_axil_wdata   <= {24'h000000, d};
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid  <= 1'b1;
    s_axil_bready  <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge clk);
      if (s_axil_awready && !ad)
      begin
        s_axil_awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (s_axil_wready && !wd)
      begin
        s_axil_wvalid <= 1'b0;
        wd = 1'b1;
      end
    end
    do @(posedge clk); while (!s_axil_bvalid);
    check("bresp", s_axil_bresp, er);
    s_axil_bready <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] ed, input logic [1:0] er);
    @(posedge clk);
    s_axil_araddr  <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready  <= 1'b1;
    do @(posedge clk); while (!s_axil_arready);
    s_axil_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axil_rvalid);
    check("rdata", s_axil_rdata, {24'h000000, ed});
    check("rresp", s_axil_rresp, er);
    s_axil_rready <= 1'b0;
  endtask

  task automatic pulse(input logic off);
    @(posedge clk);
    turn_off_event <= off;
    turn_on_event  <= !off;
    @(posedge clk);
    turn_off_event <= 1'b0;
    turn_on_event  <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_defaults(input logic [3:0] a, input logic [21:0] b);
    @(posedge clk);
    {otp_buck_a_step_rate, otp_buck_a_frequency_select, otp_buck_a_current_limit} <= a;
    {otp_buck_b_mode_select, otp_buck_b_sleep_voltage} <= b[21:12];
    {otp_buck_b_standby_voltage, otp_buck_b_normal_voltage} <= b[11:0];
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(A_CFG, {1'b0, a[3], 2'h0, a[2:1], 1'b0, a[0]}, OK);
    rd(B_NRM, {2'h0, b[5:0]}, OK);
    rd(B_STB, {2'h0, b[11:6]}, OK);
    rd(B_SLP, {2'h0, b[17:12]}, OK);
    rd(B_MOD, {4'h0, b[21:18]}, OK);
    @(negedge clk);
    check("cfg_out", {buck_a_step_rate, buck_a_phase_select, buck_a_frequency_select, buck_a_current_limit},
          {a[3], 2'h0, a[2:0]});
    check("mode_out", buck_b_mode_select, b[21:18]);
    check("volt_out", {buck_b_enable, buck_b_high_range, buck_b_code}, {1'b1, b[5:0]});
  endtask

  task automatic t_config;
    logic [7:0] v [3] = '{8'hff, 8'h00, 8'h52};
    foreach (v[i])
    begin
      wr(A_CFG, v[i], OK);
      rd(A_CFG, v[i] & 8'h7d, OK);
      @(negedge clk);
      check("step_rate", buck_a_step_rate, v[i][6]);
      check("phase", buck_a_phase_select, v[i][5:4]);
      check("freq", buck_a_frequency_select, v[i][3:2]);
      check("ilim", buck_a_current_limit, v[i][0]);
    end
  endtask

  task automatic tick_gap(input logic [7:0] d, input int exp);
    int n;
    wr(A_CFG, d, OK);
    repeat (2) do @(posedge clk); while (!buck_a_step_tick);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!buck_a_step_tick);
    check("tick_gap", n, exp);
  endtask

  task automatic t_voltage;
    wr(B_NRM, 8'h25, OK);
    wr(B_STB, 8'hce, OK);
    wr(B_SLP, 8'hff, OK);
    wr(B_MOD, 8'hf7, OK);
    rd(B_STB, 8'h0e, OK);
    rd(B_SLP, 8'h3f, OK);
    rd(B_MOD, 8'h27, OK);
    @(negedge clk);
    check("mode_out", buck_b_mode_select, 4'h7);
    check("normal", {buck_b_high_range, buck_b_code}, 6'h25);
    @(posedge clk);
    standby_request <= 1'b1;
    repeat (3) @(negedge clk);
    check("standby", {buck_b_high_range, buck_b_code}, 6'h0e);
    @(posedge clk);
    standby_request <= 1'b0;
    pulse(1'b1);
    check("to_sleep", buck_b_state, buck_regs_pkg::B_SLEEP);
    check("sleep", {buck_b_high_range, buck_b_code}, 6'h3f);
    rd(ST, 8'h02, OK);
    pulse(1'b0);
    check("back_on", buck_b_state, buck_regs_pkg::B_ON);
    wr(B_MOD, 8'h07, OK);
    pulse(1'b1);
    check("to_off", {buck_b_state, buck_b_enable}, {buck_regs_pkg::B_OFF, 1'b0});
    check("off_volt", {buck_b_high_range, buck_b_code}, 6'h25);
    pulse(1'b0);
  endtask

  task automatic t_unmapped;
    wr(10'h000, 8'h5a, buck_regs_pkg::RESP_SLVERR);
    rd(10'h000, 8'h00, buck_regs_pkg::RESP_SLVERR);
    wr(ST, 8'hff, OK);
    rd(ST, 8'h00, OK);
    s_axil_wstrb <= 4'h0;
    wr(A_CFG, 8'h12, OK);
    s_axil_wstrb <= 4'h1;
    rd(A_CFG, 8'h40, OK);
  endtask

  task automatic results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (8000) @(posedge clk);
    miscompares++;
    results();
  end

  initial
  begin
    {clk, rst, s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} = 7'h20;
    {standby_request, turn_off_event, turn_on_event} = 3'h0;
    {s_axil_awaddr, s_axil_araddr, s_axil_wdata} = 52'h0;
    s_axil_wstrb = 4'h1;
    {otp_buck_a_step_rate, otp_buck_a_frequency_select, otp_buck_a_current_limit} = 4'h0;
    {otp_buck_b_mode_select, otp_buck_b_normal_voltage, otp_buck_b_standby_voltage} = 16'h0;
    otp_buck_b_sleep_voltage = 6'h00;
    miscompares = 0;
    compares = 0;
    t_defaults(4'hd, {4'h9, 6'h31, 6'h13, 6'h2a});
    t_config();
    tick_gap(8'h00, buck_regs_pkg::STEP_FAST_CYCLES);
    tick_gap(8'h40, buck_regs_pkg::STEP_SLOW_CYCLES);
    t_voltage();
    t_unmapped();
    t_defaults(4'h2, {4'h6, 6'h0e, 6'h25, 6'h11});
    results();
  end
endmodule
